//--- abs_seq_pkg.sv
// Purpose: shared constants for the absolute position output link
// Assumes: one 40 MHz clock on both ends
// Notes: serial character layout and apb map are local choices
`default_nettype none
package abs_seq_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned REQ_DELAY_MS = 100;
  localparam int unsigned REQ_DELAY_CYC = CLK_HZ / 1000 * REQ_DELAY_MS;
  localparam int unsigned SETTLE_MS = 25;
  localparam int unsigned SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
  localparam int unsigned POWERUP_MS = 3000;
  localparam int unsigned POWERUP_CYC = CLK_HZ / 1000 * POWERUP_MS;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned INIT_RPM = 1250;
  localparam int unsigned INIT_PPR = 131072;
  // quadrature steps per second = rpm/60*ppr, rounded down to cycles
  localparam int unsigned INIT_STEP_CYC = (CLK_HZ / INIT_RPM * 60) / INIT_PPR;
  // serial frame
  localparam int unsigned SER_BYTES = 8;
  localparam logic [7:0] CHR_HDR = 8'h50;
  localparam logic [7:0] CHR_POS = 8'h2b;
  localparam logic [7:0] CHR_NEG = 8'h2d;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_END = 8'h0d;
  localparam logic [3:0] UART_LAST = 4'h9;
  // encoder usage setting
  localparam logic [1:0] USE_ABS_SERIAL = 2'h0;
  localparam logic [1:0] USE_INCREMENTAL = 2'h1;
  localparam logic [1:0] USE_ABS_QUIET = 2'h2;
  // alarm bit positions
  localparam int unsigned ALM_MT_ERR = 0;
  localparam int unsigned ALM_MT_OVF = 1;
  localparam int unsigned ALM_BAT1 = 2;
  localparam int unsigned ALM_BAT2 = 3;
  localparam int unsigned ALM_OVERSPEED = 4;
  localparam int unsigned ALM_GENERAL = 5;
  localparam logic [5:0] ALM_ENC_MASK = 6'h1f;
  localparam logic [5:0] ALM_BAT_MASK = 6'h0c;
  // panel display
  typedef enum logic [1:0] {
    disp_function, position_clear_prompt, error_clear_prompt, clear_done_indication
  } panel_disp_t;
  // host apb map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_TURNS = 12'h008;
  localparam logic [11:0] REG_COUNT = 12'h00c;
  localparam logic [11:0] REG_PS = 12'h010;
  localparam logic [11:0] REG_PPR = 12'h014;
  localparam logic [11:0] REG_POS = 12'h018;
  localparam int unsigned CTRL_REQ = 0;
  localparam int unsigned CTRL_REV = 1;
  localparam logic [31:0] PPR_RESET = 32'h0002_0000;
endpackage : abs_seq_pkg
`default_nettype wire

//--- abs_link_if.sv
// Purpose: pins between drive and motion controller
// Assumes: both ends on the same clock
// Notes: all pins are one-way
`default_nettype none
interface abs_link_if;
  logic absolute_data_request;
  logic pulse_out_a;
  logic pulse_out_b;
  logic origin_pulse_out;
  modport device (input absolute_data_request, output pulse_out_a, output pulse_out_b, output origin_pulse_out);
  modport host (output absolute_data_request, input pulse_out_a, input pulse_out_b, input origin_pulse_out);
endinterface : abs_link_if
`default_nettype wire

//--- abs_pos_device.sv
// Purpose: drive side absolute position output sequencer
// Assumes: panel keys, alarm events and turn pulses are same-clock pulses
// Notes: encoder a/b/z pins are resynchronised
`default_nettype none
module abs_pos_device
  import abs_seq_pkg::*;
#(
  parameter int unsigned REQ_CYC = REQ_DELAY_CYC,
  parameter int unsigned SET_CYC = SETTLE_CYC,
  parameter int unsigned BITC = BIT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to controller
  abs_link_if.device link,
  // configuration and servo
  input wire logic [1:0] usage_setting,
  input wire logic servo_on_input,
  input wire logic servo_power,
  input wire logic battery_connected,
  // encoder
  input wire logic [2:0] enc_abz_pin,
  input wire logic [16:0] enc_position,
  input wire logic turn_up,
  input wire logic turn_down,
  input wire logic [5:0] alarm_event,
  // panel and alarm reset
  input wire logic general_alarm_reset_input,
  input wire logic func_sel,
  input wire logic key_func,
  input wire logic key_set,
  // status
  output logic motor_enable,
  output logic [5:0] alarm,
  output logic signed [15:0] turns,
  output logic setup_required,
  output logic setup_refused,
  output panel_disp_t panel_disp
);
  typedef enum logic [2:0] {st_idle, st_wait, st_serial, st_initp, st_settle, st_normal} seq_t;
  seq_t st_ff;
  logic [1:0] usage_ff;
  logic latched_ff;
  logic req_d_ff;
  logic [2:0] abz_s1_ff, abz_ff;
  logic [31:0] tmr_ff, set_tmr_ff;
  logic [2:0] byte_ff;
  logic [3:0] bit_ff;
  logic [9:0] shift_ff;
  logic [16:0] left_ff;
  logic [1:0] qph_ff;
  logic pa_ff, pb_ff, pc_ff;
  logic ready_ff, motor_ff, lost_ff, refused_ff;
  logic [5:0] alm_ff;
  logic signed [15:0] turns_ff;
  panel_disp_t disp_ff;
  logic req_rise, abs_mode, bit_end, step, do_setup, do_clear;
  logic [7:0] cur_byte;

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < 4'ha) ? (CHR_ZERO + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_chr

  // settings latch at reset release
  // latch once after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usage_ff <= USE_ABS_SERIAL;
      latched_ff <= 1'b0;
    end else if (!latched_ff) begin
      usage_ff <= usage_setting;
      latched_ff <= 1'b1;
    end
  end

  // encoder pins two flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abz_s1_ff <= 3'h0;
      abz_ff <= 3'h0;
      req_d_ff <= 1'b0;
    end else begin
      abz_s1_ff <= enc_abz_pin;
      abz_ff <= abz_s1_ff;
      req_d_ff <= link.absolute_data_request;
    end
  end

  assign abs_mode = latched_ff && (usage_ff == USE_ABS_SERIAL);
  assign req_rise = abs_mode && link.absolute_data_request && !req_d_ff;
  assign bit_end = (tmr_ff == BITC - 1);
  assign step = (tmr_ff == INIT_STEP_CYC - 1);

  // next character, loaded as the one indexed by byte_ff ends
  // header goes out from the wait exit load
  always_comb begin
    case (byte_ff)
      3'h0: cur_byte = turns_ff[15] ? CHR_NEG : CHR_POS;
      3'h1: cur_byte = CHR_ZERO;
      3'h2: cur_byte = hex_chr(turns_ff[15:12]);
      3'h3: cur_byte = hex_chr(turns_ff[11:8]);
      3'h4: cur_byte = hex_chr(turns_ff[7:4]);
      3'h5: cur_byte = hex_chr(turns_ff[3:0]);
      default: cur_byte = CHR_END;
    endcase
  end

  // output sequence state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= st_idle;
      tmr_ff <= 32'h0;
      set_tmr_ff <= 32'h0;
      byte_ff <= 3'h0;
      bit_ff <= 4'h0;
      shift_ff <= 10'h3ff;
      left_ff <= 17'h0;
      qph_ff <= 2'h0;
    end else if (req_rise) begin
      st_ff <= st_wait;
      tmr_ff <= 32'h0;
    end else begin
      case (st_ff)
        st_idle: begin
          if (latched_ff && !abs_mode)
            st_ff <= st_normal;
        end
        st_wait: begin
          tmr_ff <= tmr_ff + 32'h1;
          if (tmr_ff == REQ_CYC - 1) begin
            st_ff <= st_serial;
            tmr_ff <= 32'h0;
            byte_ff <= 3'h0;
            bit_ff <= 4'h0;
            qph_ff <= 2'h1; // a high, b low: no false edge after the stop bit
            left_ff <= enc_position;
            shift_ff <= {1'b1, CHR_HDR, 1'b0};
          end
        end
        // start, 8 data lsb first, stop
        st_serial: begin
          tmr_ff <= bit_end ? 32'h0 : tmr_ff + 32'h1;
          if (bit_end) begin
            shift_ff <= {1'b1, shift_ff[9:1]};
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == UART_LAST) begin
              bit_ff <= 4'h0;
              byte_ff <= byte_ff + 3'h1;
              shift_ff <= {1'b1, cur_byte, 1'b0};
              if (byte_ff == 3'(SER_BYTES - 1)) begin
                st_ff <= st_initp;
                set_tmr_ff <= 32'h0;
              end
            end
          end
        end
        st_initp: begin
          set_tmr_ff <= set_tmr_ff + 32'h1;
          tmr_ff <= step ? 32'h0 : tmr_ff + 32'h1;
          if (left_ff == 17'h0)
            st_ff <= st_settle;
          else if (step) begin
            left_ff <= left_ff - 17'h1;
            qph_ff <= qph_ff + 2'h1;
          end
        end
        st_settle: begin
          set_tmr_ff <= set_tmr_ff + 32'h1;
          if (set_tmr_ff >= SET_CYC - 1)
            st_ff <= st_normal;
        end
        st_normal: st_ff <= st_normal;
        default: st_ff <= st_idle;
      endcase
    end
  end

  // first byte is loaded at wait exit; later ones follow cur_byte
  // pin multiplexing per phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_ff <= 1'b1;
      pb_ff <= 1'b0;
      pc_ff <= 1'b0;
    end else begin
      pc_ff <= abz_ff[2];
      case (st_ff)
        st_serial: begin
          pa_ff <= shift_ff[0];
          pb_ff <= 1'b0;
        end
        st_initp, st_settle: begin
          pa_ff <= qph_ff[1] ^ qph_ff[0];
          pb_ff <= qph_ff[1];
        end
        st_normal: begin
          pa_ff <= abz_ff[0];
          pb_ff <= abz_ff[1];
        end
        default: begin
          pa_ff <= 1'b1;
          pb_ff <= 1'b0;
        end
      endcase
    end
  end

  // panel key sequence
  // prompt, execute, done
  assign do_setup = (disp_ff == position_clear_prompt) && key_func && !servo_on_input;
  assign do_clear = (disp_ff == error_clear_prompt) && key_func;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_ff <= disp_function;
      refused_ff <= 1'b0;
    end else begin
      case (disp_ff)
        disp_function: begin
          if (key_set) begin
            disp_ff <= func_sel ? error_clear_prompt : position_clear_prompt;
            refused_ff <= 1'b0;
          end
        end
        position_clear_prompt: begin
          if (do_setup)
            disp_ff <= clear_done_indication;
          else if (key_func)
            refused_ff <= 1'b1;
        end
        error_clear_prompt: begin
          if (do_clear)
            disp_ff <= clear_done_indication;
        end
        clear_done_indication: begin
          if (key_set)
            disp_ff <= disp_function;
        end
        default: disp_ff <= disp_function;
      endcase
    end
  end

  // multi-turn count
  // natural 16-bit wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      turns_ff <= 16'sh0;
    else if (do_setup)
      turns_ff <= 16'sh0;
    else if (turn_up && !turn_down)
      turns_ff <= turns_ff + 16'sh1;
    else if (turn_down && !turn_up)
      turns_ff <= turns_ff - 16'sh1;
  end

  // sticky alarms, set wins over clear
  // general reset spares encoder alarms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      alm_ff <= 6'h0;
    else begin
      alm_ff <= (alm_ff & ~(do_clear ? ALM_ENC_MASK : 6'h0)
                       & ~(general_alarm_reset_input ? ~ALM_ENC_MASK : 6'h0))
                | (alarm_event & ((usage_ff == USE_INCREMENTAL) ? ~ALM_BAT_MASK : 6'h3f))
                | {4'h0, (turn_up && turns_ff == 16'sh7fff) || (turn_down && turns_ff == -16'sh8000), 1'b0};
    end
  end

  // lost position and motor gate
  // unpowered and battery removed
  // motor held off until sequence done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lost_ff <= 1'b0;
      ready_ff <= 1'b0;
      motor_ff <= 1'b0;
    end else begin
      if (!servo_power && !battery_connected && latched_ff && usage_ff != USE_INCREMENTAL)
        lost_ff <= 1'b1;
      else if (do_setup)
        lost_ff <= 1'b0;
      ready_ff <= (st_ff == st_normal);
      motor_ff <= servo_on_input && ready_ff && !req_rise;
    end
  end

  assign link.pulse_out_a = pa_ff;
  assign link.pulse_out_b = pb_ff;
  assign link.origin_pulse_out = pc_ff;
  assign motor_enable = motor_ff;
  assign alarm = alm_ff;
  assign turns = turns_ff;
  assign setup_required = lost_ff;
  assign setup_refused = refused_ff;
  assign panel_disp = disp_ff;
endmodule : abs_pos_device
`default_nettype wire

//--- abs_pos_host.sv
// Purpose: controller side, requests and decodes absolute position
// Assumes: software reaches the registers over apb
// Notes: zero wait-state slave, pready from a flop
`default_nettype none
module abs_pos_host
  import abs_seq_pkg::*;
#(
  parameter int unsigned PWR_CYC = POWERUP_CYC,
  parameter int unsigned BITC = BIT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to drive
  abs_link_if.host link
);
  logic [31:0] pwr_ff, bt_ff, cnt_ff, ps_ff, ppr_ff, rdata_ff;
  logic [1:0] ctrl_ff;
  logic armed_ff, req_ff, rx_on_ff, busy_ff, valid_ff, ferr_ff, rdy_ff, err_ff;
  logic [3:0] rbit_ff;
  logic [2:0] rbyte_ff;
  logic [7:0] rsh_ff;
  logic [15:0] turns_ff;
  logic ap_ff, bp_ff;
  logic [31:0] mt, pe;
  logic wr, mapped;

  // hold request low for three seconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ff <= 32'h0;
      armed_ff <= 1'b0;
      req_ff <= 1'b0;
    end else begin
      if (!armed_ff)
        pwr_ff <= pwr_ff + 32'h1;
      if (pwr_ff == PWR_CYC - 1)
        armed_ff <= 1'b1;
      req_ff <= armed_ff && ctrl_ff[CTRL_REQ];
    end
  end

  // serial receiver, mid-bit sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_on_ff <= 1'b0;
      busy_ff <= 1'b0;
      valid_ff <= 1'b0;
      ferr_ff <= 1'b0;
      bt_ff <= 32'h0;
      rbit_ff <= 4'h0;
      rbyte_ff <= 3'h0;
      rsh_ff <= 8'h0;
      turns_ff <= 16'h0;
    end else if (armed_ff && ctrl_ff[CTRL_REQ] && !req_ff) begin
      rx_on_ff <= 1'b1;
      valid_ff <= 1'b0;
      ferr_ff <= 1'b0;
      busy_ff <= 1'b0;
      rbyte_ff <= 3'h0;
    end else if (rx_on_ff) begin
      if (!busy_ff) begin
        if (!link.pulse_out_a) begin
          busy_ff <= 1'b1;
          bt_ff <= 32'h0;
          rbit_ff <= 4'h0;
        end
      end else if (bt_ff == (rbit_ff == 4'h0 ? BITC / 2 : BITC) - 1) begin
        bt_ff <= 32'h0;
        rbit_ff <= rbit_ff + 4'h1;
        if (rbit_ff != 4'h0 && rbit_ff != UART_LAST)
          rsh_ff <= {link.pulse_out_a, rsh_ff[7:1]};
        if (rbit_ff == UART_LAST) begin
          busy_ff <= 1'b0;
          rbyte_ff <= rbyte_ff + 3'h1;
          if (!link.pulse_out_a)
            ferr_ff <= 1'b1;
          if (rbyte_ff >= 3'h3 && rbyte_ff <= 3'h6)
            turns_ff <= {turns_ff[11:0], rsh_ff[6] ? rsh_ff[3:0] + 4'h9 : rsh_ff[3:0]};
          if (rbyte_ff == 3'(SER_BYTES - 1)) begin
            rx_on_ff <= 1'b0;
            valid_ff <= 1'b1;
          end
        end
      end else
        bt_ff <= bt_ff + 32'h1;
    end
  end

  // reversible pulse counter, cleared on request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 32'h0;
      ap_ff <= 1'b1;
      bp_ff <= 1'b0;
    end else begin
      ap_ff <= link.pulse_out_a;
      bp_ff <= link.pulse_out_b;
      if (rx_on_ff || !valid_ff)
        cnt_ff <= 32'h0;
      else if ((link.pulse_out_a ^ ap_ff) != (link.pulse_out_b ^ bp_ff))
        cnt_ff <= (link.pulse_out_a ^ bp_ff) ? cnt_ff + 32'h1 : cnt_ff - 32'h1;
    end
  end

  // position = turns*ppr + count - ps, turns negated when CTRL_REV is set
  assign mt = {{16{turns_ff[15]}}, turns_ff};
  assign pe = (ctrl_ff[CTRL_REV] ? 32'h0 - mt : mt) * ppr_ff + cnt_ff;
  assign wr = psel && penable && rdy_ff && pwrite;
  assign mapped = (paddr <= REG_POS) && (paddr[1:0] == 2'h0);

  // apb registers and read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 2'h0;
      ps_ff <= 32'h0;
      ppr_ff <= PPR_RESET;
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      rdy_ff <= psel && !penable;
      err_ff <= psel && !penable && !mapped;
      if (wr && paddr == REG_CTRL)
        ctrl_ff <= pwdata[1:0];
      if (wr && paddr == REG_PS)
        ps_ff <= pwdata;
      if (wr && paddr == REG_PPR)
        ppr_ff <= pwdata;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          REG_CTRL: rdata_ff <= {30'h0, ctrl_ff};
          REG_STATUS: rdata_ff <= {28'h0, ferr_ff, valid_ff, rx_on_ff, armed_ff};
          REG_TURNS: rdata_ff <= mt;
          REG_COUNT: rdata_ff <= cnt_ff;
          REG_PS: rdata_ff <= ps_ff;
          REG_PPR: rdata_ff <= ppr_ff;
          REG_POS: rdata_ff <= pe - ps_ff;
          default: rdata_ff <= 32'h0;
        endcase
      end
    end
  end

  assign link.absolute_data_request = req_ff;
  assign prdata = rdata_ff;
  assign pready = rdy_ff;
  assign pslverr = err_ff;
endmodule : abs_pos_host
`default_nettype wire

//--- abs_seq_checker.sv
// Purpose: link timing checks beside the drive/controller link
// Assumes: usage setting held steady between resets
// Notes: counters replace long repetitions
`default_nettype none
module abs_seq_checker
  import abs_seq_pkg::*;
#(
  parameter int REQ_CYC = 40,
  parameter int PWR_CYC = 50,
  parameter int BITC = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link pins
  input wire logic absolute_data_request,
  input wire logic pulse_out_a,
  input wire logic pulse_out_b,
  input wire logic origin_pulse_out,
  // drive pins
  input wire logic [1:0] usage_setting,
  input wire logic [2:0] enc_abz_pin,
  input wire logic motor_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int REQ_HI = REQ_CYC + 8;
  localparam int SER_END = REQ_CYC + 80 * BITC;
  int up_ff;
  int rq_ff;
  logic ser;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_ff <= 0;
    else if (up_ff < PWR_CYC) up_ff <= up_ff + 1;
  end
  // cycles since request went high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rq_ff <= 0;
    else if (!absolute_data_request) rq_ff <= 0;
    else if (rq_ff <= SER_END) rq_ff <= rq_ff + 1;
  end
  // wait and serial phase of an absolute request
  assign ser = usage_setting == USE_ABS_SERIAL && absolute_data_request && rq_ff < SER_END;
  req_guard_a: assert property ($rose(absolute_data_request) |-> up_ff >= PWR_CYC)
    else $error("request before power-up wait");
  wait_high_a: assert property (ser && rq_ff < REQ_CYC |-> pulse_out_a)
    else $error("a left idle before wait ended");
  start_bit_a: assert property (usage_setting == USE_ABS_SERIAL && $rose(absolute_data_request)
    |-> ##[REQ_CYC:REQ_HI] !pulse_out_a)
    else $error("no start bit after wait");
  b_low_a: assert property (ser |-> !pulse_out_b)
    else $error("b moved during serial phase");
  motor_off_a: assert property (ser |-> !motor_enable)
    else $error("motor on during sequence");
  a_pass_a: assert property (usage_setting != USE_ABS_SERIAL && $changed(pulse_out_a)
    |-> pulse_out_a == $past(enc_abz_pin[0], 2) || pulse_out_a == $past(enc_abz_pin[0], 3))
    else $error("a not following encoder");
  b_pass_a: assert property (usage_setting != USE_ABS_SERIAL && $changed(pulse_out_b)
    |-> pulse_out_b == $past(enc_abz_pin[1], 2) || pulse_out_b == $past(enc_abz_pin[1], 3))
    else $error("b not following encoder");
  origin_pass_a: assert property ($changed(origin_pulse_out)
    |-> origin_pulse_out == $past(enc_abz_pin[2], 2) || origin_pulse_out == $past(enc_abz_pin[2], 3))
    else $error("origin not following encoder");
  // main scenarios
  cover property ($rose(absolute_data_request));
  cover property (ser ##1 !pulse_out_a);
  cover property ($rose(motor_enable));
endmodule : abs_seq_checker
`default_nettype wire

//--- absolute_position_output_sequencer_tb.sv
// Purpose: drive and controller joined, checked over apb
// Assumes: shortened counts for wait, settle and bit time
// Notes: long wrap run dominates run time
`default_nettype none
module absolute_position_output_sequencer_tb;
  import abs_seq_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RQ = 40;
  localparam int ST = 2000;
  localparam int BC = 16;
  localparam int PW = 50;
  logic pclk = 0;
  logic presetn = 0;
  logic [1:0] usage = '0;
  logic son = 0, spwr = 1, bat = 1, tup = 0, tdn = 0, gar = 0, fsel = 0, kf = 0, ks = 0;
  logic [2:0] enc = 3'h3; // a and b high: phase reached after five steps
  logic [16:0] epos = '0;
  logic [5:0] aev = '0;
  logic [11:0] paddr = '0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, motor_enable, setup_required, setup_refused;
  logic [5:0] alarm;
  logic signed [15:0] turns;
  panel_disp_t panel_disp;
  int miscompares = 0;
  int n_checks = 0;
  // clock
  always #12.5 pclk = ~pclk;
  abs_link_if u_abs_link_if ();
  abs_pos_device #(.REQ_CYC(RQ), .SET_CYC(ST), .BITC(BC)) u_abs_pos_device (.pclk(pclk), .presetn(presetn),
    .link(u_abs_link_if.device), .usage_setting(usage), .servo_on_input(son), .servo_power(spwr),
    .battery_connected(bat), .enc_abz_pin(enc), .enc_position(epos), .turn_up(tup), .turn_down(tdn),
    .alarm_event(aev), .general_alarm_reset_input(gar), .func_sel(fsel), .key_func(kf), .key_set(ks),
    .motor_enable(motor_enable), .alarm(alarm), .turns(turns), .setup_required(setup_required),
    .setup_refused(setup_refused), .panel_disp(panel_disp));
  abs_pos_host #(.PWR_CYC(PW), .BITC(BC)) u_abs_pos_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(u_abs_link_if.host));
  abs_seq_checker #(.REQ_CYC(RQ), .PWR_CYC(PW), .BITC(BC)) u_abs_seq_checker (.pclk(pclk), .presetn(presetn),
    .absolute_data_request(u_abs_link_if.absolute_data_request), .pulse_out_a(u_abs_link_if.pulse_out_a),
    .pulse_out_b(u_abs_link_if.pulse_out_b), .origin_pulse_out(u_abs_link_if.origin_pulse_out),
    .usage_setting(usage), .enc_abz_pin(enc), .motor_enable(motor_enable));
  task automatic stop_test;
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      miscompares++;
      stop_test();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask : rd
  task automatic rst(input logic [1:0] u);
    presetn <= 1'b0;
    usage <= u;
    cyc(4);
    presetn <= 1'b1;
    cyc(2);
  endtask : rst
  // one panel key press: 1 function key, 0 set key
  task automatic key(input logic f);
    if (f) kf <= 1'b1;
    else ks <= 1'b1;
    cyc(1);
    kf <= 1'b0;
    ks <= 1'b0;
    cyc(2);
  endtask : key
  task automatic step(input logic dn);
    if (dn) tdn <= 1'b1;
    else tup <= 1'b1;
    cyc(1);
    tdn <= 1'b0;
    tup <= 1'b0;
    cyc(1);
  endtask : step
  // main sequence
  initial begin
    rst(USE_ABS_SERIAL);
    rd("ppr", REG_PPR, PPR_RESET, 1'b0);
    rd("unmapped", 12'h01c, 32'h0, 1'b1);
    repeat (3) step(1'b0);
    son <= 1'b1;
    epos <= 17'd5;
    cyc(PW + 10);
    wr(REG_PS, 32'h2);
    wr(REG_CTRL, 32'h1);
    cyc(RQ + 80 * BC + ST + 100);
    rd("turns", REG_TURNS, 32'h3, 1'b0);
    rd("count", REG_COUNT, 32'h5, 1'b0);
    rd("status", REG_STATUS, 32'h5, 1'b0);
    rd("pos", REG_POS, 32'h0006_0003, 1'b0);
    chk("motor", 32'h1, {31'h0, motor_enable});
    wr(REG_CTRL, 32'h3);
    rd("pos_rev", REG_POS, 32'hfffa_0003, 1'b0);
    repeat (32765) step(1'b0);
    chk("wrap_up", 32'h8000, {16'h0, turns});
    step(1'b1);
    chk("wrap_dn", 32'h7fff, {16'h0, turns});
    aev <= 6'h25;
    cyc(1);
    aev <= 6'h00;
    gar <= 1'b1;
    cyc(1);
    gar <= 1'b0;
    cyc(2);
    chk("alarm_gen", 32'h7, {26'h0, alarm});
    son <= 1'b0;
    fsel <= 1'b1;
    key(1'b0);
    chk("disp_err", 32'h2, {30'h0, panel_disp});
    key(1'b1);
    chk("disp_done", 32'h3, {30'h0, panel_disp});
    chk("alarm_clr", 32'h0, {26'h0, alarm});
    key(1'b0);
    chk("disp_fn", 32'h0, {30'h0, panel_disp});
    spwr <= 1'b0;
    bat <= 1'b0;
    cyc(4);
    chk("lost", 32'h1, {31'h0, setup_required});
    spwr <= 1'b1;
    bat <= 1'b1;
    fsel <= 1'b0;
    son <= 1'b1;
    key(1'b0);
    chk("disp_pos", 32'h1, {30'h0, panel_disp});
    key(1'b1);
    chk("refused", 32'h1, {31'h0, setup_refused});
    chk("disp_hold", 32'h1, {30'h0, panel_disp});
    son <= 1'b0;
    cyc(4);
    key(1'b1);
    chk("disp_done2", 32'h3, {30'h0, panel_disp});
    chk("turns_zero", 32'h0, {16'h0, turns});
    chk("lost_clr", 32'h0, {31'h0, setup_required});
    key(1'b0);
    chk("disp_fn2", 32'h0, {30'h0, panel_disp});
    rst(USE_INCREMENTAL);
    son <= 1'b1;
    cyc(PW + 10);
    wr(REG_CTRL, 32'h1);
    repeat (8) begin
      enc <= {~enc[2], enc[0], ~enc[1]};
      cyc(20);
    end
    cyc(RQ + 80 * BC);
    rd("count_inc", REG_COUNT, 32'h0, 1'b0);
    aev <= 6'h04;
    cyc(1);
    aev <= 6'h00;
    cyc(2);
    chk("bat_masked", 32'h0, {31'h0, alarm[ALM_BAT1]});
    rst(USE_ABS_QUIET);
    cyc(5);
    chk("motor_quiet", 32'h1, {31'h0, motor_enable});
    // usage change without reset must not mask battery alarms
    usage <= USE_INCREMENTAL;
    aev <= 6'h04;
    cyc(1);
    aev <= 6'h00;
    cyc(2);
    chk("bat_latched", 32'h1, {31'h0, alarm[ALM_BAT1]});
    stop_test();
  end
endmodule : absolute_position_output_sequencer_tb
`default_nettype wire
